// File: hdl/vad_pkg.sv
package vad_pkg;
   // pseudo-float pair: value = 2^exp * (man / 32768)
   typedef struct packed {
      logic signed [15:0] exp;
      logic        [15:0] man;
   } vad_pf_t;

   localparam int VAD_LAGS = 9;   // autocorrelation lags 0..8
   localparam int VAD_NRC  = 4;   // reflection coefficients used

   // operands handed over once per frame by the speech encoder
   typedef struct packed {
      logic signed [VAD_LAGS-1:0][31:0] acf;   // frame autocorrelation
      logic signed [VAD_LAGS-1:0][15:0] fcorr; // filter coeff autocorr
      logic signed [VAD_NRC-1:0][15:0]  reflection_coeffs; // Q15
   } vad_frame_t;

   localparam logic [15:0]        VAD_MAN_MIN  = 16'h4000; // 16384
   localparam int                 VAD_MAN_BITS = 15;       // /32768
   localparam logic signed [15:0] VAD_EXP_ZERO = 16'sh8000;

   // energy floor, upper margin, threshold lower limit
   localparam vad_pf_t VAD_ENERGY_FLOOR = '{16'sh0011, 16'h7EF4};
   localparam vad_pf_t VAD_MARGIN       = '{16'sh001B, 16'h421F};
   localparam vad_pf_t VAD_THR_LIMIT    = '{16'sh0013, 16'h54A3};

   // tone detection thresholds in Q15 (0.0973, 0.0447)
   localparam logic signed [15:0] VAD_FREQ_TH = 16'sh0C74;
   localparam logic signed [15:0] VAD_PRED_TH = 16'sh05B9;
   localparam logic signed [15:0] VAD_Q15_ONE = 16'sh7FFF;

   localparam logic [3:0] VAD_LAST_LAG = 4'h8;
endpackage

// File: hdl/vad_pole_test.sv
// Notes on behaviour
// - pvad, threshold and frame energy are carried as pseudo-float pairs
// - each pair is a 16-bit exponent word and a 16-bit mantissa word
// - exponent is the smallest power of two above the value
// - mantissa stays at or above 16384 after every operation
// - value equals two to the exponent times mantissa over 32768
// - comparisons are decided first on the exponent words
// - one pseudo-float add and one multiply, from plain integer ops
// - energy floor constant is exponent 17, mantissa 32500
// - upper threshold margin constant is exponent 27, mantissa 16927
// - threshold lower limit constant is exponent 19, mantissa 21667
// - filtered energy covers outputs 0..167 from input samples 0..159
// - energy sums lag 0..8 autocorrelation times coefficient autocorr
// - negative four a2 minus a1 squared: real poles, no tone, stop
// - negative pole real part: skip low-frequency check, go to error test
// - imag over a1 squared below 0.0973 means below 385 Hz: no tone
// - tone when product of one minus rc squared is below 0.0447
// - raw decision is filtered energy strictly above the threshold
module vad_pole_test
   import vad_pkg::*;
(
   input  wire logic               clk,          // 250 MHz clock
   input  wire logic               nrst,         // sync reset, active low
   input  wire logic               start,        // pulse: frame is valid
   input  wire vad_pkg::vad_frame_t frame,       // per-frame operands
   input  wire vad_pkg::vad_pf_t   thvad,        // decision threshold
   input  wire vad_pkg::vad_pf_t   thr_scale,    // factor for the multiply
   output vad_pkg::vad_pf_t        pvad_r,       // filtered-block energy
   output vad_pkg::vad_pf_t        input_frame_energy_r, // lag-0 energy
   output vad_pkg::vad_pf_t        ceiling_r,    // pvad plus margin
   output vad_pkg::vad_pf_t        thr_scaled_r, // thvad times thr_scale
   output vad_pkg::vad_pf_t        thr_floored_r, // thvad, not below limit
   output logic                    below_floor_r, // frame energy < floor
   output logic                    vad_raw_r,    // pvad > thvad
   output logic                    tone_r,       // information tone seen
   output logic                    busy_r,       // frame in progress
   output logic                    done_r        // pulse: results valid
);
   import vad_pkg::*;

   typedef enum logic [1:0] {VAD_ST_IDLE, VAD_ST_ACC, VAD_ST_FIN} vad_st_t;

   // normalise a non-negative integer into a pair
   function automatic vad_pf_t vad_norm(input logic signed [63:0] v);
      vad_pf_t r;
      int      p;
      logic [63:0] u;
      p = -1;
      u = 64'h0;
      r = '{VAD_EXP_ZERO, VAD_MAN_MIN};
      if (v > 0) begin
         u = 64'(v);
         for (int i = 0; i < 63; i++) begin
            if (u[i]) begin
               p = i;
            end
         end
         r.exp = 16'(p + 1);
         if (p >= VAD_MAN_BITS - 1) begin
            r.man = 16'(u >> (p + 1 - VAD_MAN_BITS));
         end else begin
            r.man = 16'(u << (VAD_MAN_BITS - 1 - p));
         end
      end
      return r;
   endfunction

   // a greater than b; exponents first, mantissas on a tie
   function automatic logic vad_gt(input vad_pf_t a, input vad_pf_t b);
      if (a.exp != b.exp) begin
         return a.exp > b.exp;
      end
      return a.man > b.man;
   endfunction

   // the single addition: align on the larger exponent, then renormalise
   function automatic vad_pf_t vad_add(input vad_pf_t a, input vad_pf_t b);
      vad_pf_t     r;
      vad_pf_t     big;
      vad_pf_t     sml;
      logic [16:0] s;
      logic [16:0] d;
      big = vad_gt(a, b) ? a : b;
      sml = vad_gt(a, b) ? b : a;
      d = 17'(big.exp) - 17'(sml.exp);
      s = {1'b0, big.man};
      if (d < 17'd16) begin
         s = s + 17'(sml.man >> d[3:0]);
      end
      r = big;
      if (s[15]) begin
         r.exp = big.exp + 16'sh0001;
         r.man = s[16:1];
      end else begin
         r.man = s[15:0];
      end
      return r;
   endfunction

   // the single multiply: mantissa product scaled back by 32768
   function automatic vad_pf_t vad_mul(input vad_pf_t a, input vad_pf_t b);
      vad_pf_t     r;
      logic [31:0] pr;
      pr = 32'(a.man) * 32'(b.man);
      r.exp = a.exp + b.exp;
      r.man = 16'(pr >> VAD_MAN_BITS);
      if (r.man < VAD_MAN_MIN) begin
         r.man = 16'(pr >> (VAD_MAN_BITS - 1));
         r.exp = r.exp - 16'sh0001;
      end
      return r;
   endfunction

   // information tone test on the frame's reflection coefficients
   function automatic logic vad_tone(input vad_frame_t f);
      logic signed [31:0] refl1;
      logic signed [31:0] refl2;
      logic signed [31:0] a1;
      logic signed [47:0] den;
      logic signed [47:0] num;
      logic signed [31:0] pe;
      logic signed [31:0] t;
      logic               go_err;
      // a packed element selects unsigned, so its sign is restored here
      refl1 = 32'($signed(f.reflection_coeffs[0]));
      refl2 = 32'($signed(f.reflection_coeffs[1]));
      a1 = refl1 + ((refl1 * refl2) >>> 15);
      den = 48'(a1) * 48'(a1);                                  // Q30
      num = (48'(refl2) <<< 17) - den;                          // 4*a2-a1^2
      if (num <= 0) begin
         return 1'b0;
      end
      // a1 >= 0 means the real part is not positive: skip frequency check
      go_err = (a1 >= 0);
      if (!go_err) begin
         go_err = (num <<< 15) >= 48'(VAD_FREQ_TH) * den;
      end
      if (!go_err) begin
         return 1'b0;
      end
      pe = 32'(VAD_Q15_ONE);
      for (int i = 0; i < VAD_NRC; i++) begin
         t = 32'($signed(f.reflection_coeffs[i]));
         t = 32'(VAD_Q15_ONE) - ((t * t) >>> 15);
         pe = (pe * t) >>> 15;
      end
      return pe < 32'(VAD_PRED_TH);
   endfunction

   vad_st_t            st_r, st_nxt;
   vad_frame_t         frm_r, frm_nxt;
   logic [3:0]         lag_r, lag_nxt;
   logic signed [63:0] acc_r, acc_nxt;
   vad_pf_t            pvad_nxt, ife_nxt, ceil_nxt, scl_nxt, flr_nxt;
   logic               blw_nxt, raw_nxt, tone_nxt, busy_nxt, done_nxt;
   logic signed [63:0] term;

   // sequencer: one lag term per cycle, results settle in the final state
   always_comb begin
      st_nxt   = st_r;
      frm_nxt  = frm_r;
      lag_nxt  = lag_r;
      acc_nxt  = acc_r;
      pvad_nxt = pvad_r;
      ife_nxt  = input_frame_energy_r;
      ceil_nxt = ceiling_r;
      scl_nxt  = thr_scaled_r;
      flr_nxt  = thr_floored_r;
      blw_nxt  = below_floor_r;
      raw_nxt  = vad_raw_r;
      tone_nxt = tone_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      // lags above zero appear twice in the expanded square
      term = 64'($signed(frm_r.fcorr[lag_r]))
             * 64'($signed(frm_r.acf[lag_r]));
      if (lag_r != 4'h0) begin
         term = term <<< 1;
      end
      case (st_r)
         VAD_ST_IDLE: begin
            if (start) begin
               frm_nxt  = frame;
               lag_nxt  = 4'h0;
               acc_nxt  = 64'sh0;
               busy_nxt = 1'b1;
               st_nxt   = VAD_ST_ACC;
            end
         end
         VAD_ST_ACC: begin
            acc_nxt = acc_r + term;
            lag_nxt = lag_r + 4'h1;
            if (lag_r == VAD_LAST_LAG) begin
               st_nxt = VAD_ST_FIN;
            end
         end
         VAD_ST_FIN: begin
            // a negative sum can only come from rounding; clamped to zero
            pvad_nxt = vad_norm(acc_r);
            ife_nxt  = vad_norm(64'($signed(frm_r.acf[0])));
            ceil_nxt = vad_add(pvad_nxt, VAD_MARGIN);
            scl_nxt  = vad_mul(thvad, thr_scale);
            flr_nxt  = vad_gt(VAD_THR_LIMIT, thvad) ?
                       VAD_THR_LIMIT : thvad;
            blw_nxt  = vad_gt(VAD_ENERGY_FLOOR, ife_nxt);
            raw_nxt  = vad_gt(pvad_nxt, thvad);
            tone_nxt = vad_tone(frm_r);
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt   = VAD_ST_IDLE;
         end
         default: begin
            st_nxt = VAD_ST_IDLE;
         end
      endcase
   end

   // registers only; start is ignored while busy
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r                 <= VAD_ST_IDLE;
         frm_r                <= '0;
         lag_r                <= 4'h0;
         acc_r                <= 64'sh0;
         pvad_r               <= '{VAD_EXP_ZERO, VAD_MAN_MIN};
         input_frame_energy_r <= '{VAD_EXP_ZERO, VAD_MAN_MIN};
         ceiling_r            <= VAD_MARGIN;
         thr_scaled_r         <= '{VAD_EXP_ZERO, VAD_MAN_MIN};
         thr_floored_r        <= VAD_THR_LIMIT;
         below_floor_r        <= 1'b0;
         vad_raw_r            <= 1'b0;
         tone_r               <= 1'b0;
         busy_r               <= 1'b0;
         done_r               <= 1'b0;
      end else begin
         st_r                 <= st_nxt;
         frm_r                <= frm_nxt;
         lag_r                <= lag_nxt;
         acc_r                <= acc_nxt;
         pvad_r               <= pvad_nxt;
         input_frame_energy_r <= ife_nxt;
         ceiling_r            <= ceil_nxt;
         thr_scaled_r         <= scl_nxt;
         thr_floored_r        <= flr_nxt;
         below_floor_r        <= blw_nxt;
         vad_raw_r            <= raw_nxt;
         tone_r               <= tone_nxt;
         busy_r               <= busy_nxt;
         done_r               <= done_nxt;
      end
   end
endmodule

// File: tb/vad_checker.sv
module vad_checker
   import vad_pkg::*;
(
   input wire logic             clk,                  // clock
   input wire logic             nrst,                 // sync reset, low
   input wire logic             start,                // frame strobe
   input wire vad_pkg::vad_pf_t thvad,                // threshold
   input wire vad_pkg::vad_pf_t pvad_r,               // filtered energy
   input wire vad_pkg::vad_pf_t input_frame_energy_r, // lag-0 energy
   input wire vad_pkg::vad_pf_t ceiling_r,            // energy plus margin
   input wire vad_pkg::vad_pf_t thr_floored_r,        // limited threshold
   input wire logic             below_floor_r,        // energy under floor
   input wire logic             vad_raw_r,            // raw decision
   input wire logic             busy_r,               // frame in progress
   input wire logic             done_r                // results valid
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam vad_pf_t PTH_C  = '{16'sh0011, 16'h7EF4};
   localparam vad_pf_t MARG_C = '{16'sh001B, 16'h421F};
   localparam vad_pf_t PLEV_C = '{16'sh0013, 16'h54A3};

   // exponent decides, mantissa only breaks a tie
   function automatic logic pf_gt(input vad_pf_t a, input vad_pf_t b);
      return (a.exp > b.exp) || (a.exp == b.exp && a.man > b.man);
   endfunction

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // a taken frame keeps the block busy, then answers once
   sequence s_take;
      start && !busy_r;
   endsequence
   sequence s_run;
      busy_r [*8] ##1 busy_r [*2];
   endsequence

   a_answer_time: assert property (
      s_take |=> s_run ##1 (done_r && !busy_r))
      else $error("done not eleven cycles after start");
   a_done_pulse: assert property (
      done_r |=> !done_r) else $error("done longer than one cycle");
   // reset changes outputs too, so skip the edge after a reset
   a_busy_end: assert property (
      $fell(busy_r) && $past(nrst) |-> done_r)
      else $error("busy dropped without done");
   a_hold_results: assert property (
      !done_r && $past(nrst) |-> $stable(pvad_r) && $stable(ceiling_r)
      && $stable(vad_raw_r) && $stable(below_floor_r))
      else $error("results moved between frames");
   a_decide_strict: assert property (
      done_r |-> vad_raw_r == pf_gt(pvad_r, thvad))
      else $error("raw decision wrong");
   a_floor_flag: assert property (
      done_r |-> below_floor_r == pf_gt(PTH_C, input_frame_energy_r))
      else $error("floor flag wrong");
   a_limit_floor: assert property (
      done_r |-> thr_floored_r == (pf_gt(PLEV_C, thvad) ? PLEV_C : thvad))
      else $error("threshold limit wrong");
   a_man_norm: assert property (
      done_r |-> pvad_r.man[15:14] == 2'b01 && ceiling_r.man[15:14] == 2'b01
      && input_frame_energy_r.man[15:14] == 2'b01)
      else $error("mantissa not normalised");
   a_ceiling_above: assert property (
      done_r |-> !pf_gt(pvad_r, ceiling_r) && !pf_gt(MARG_C, ceiling_r))
      else $error("ceiling below its terms");
endmodule

bind vad_pole_test vad_checker vad_checker_i (
   .clk(clk), .nrst(nrst), .start(start), .thvad(thvad), .pvad_r(pvad_r),
   .input_frame_energy_r(input_frame_energy_r), .ceiling_r(ceiling_r),
   .thr_floored_r(thr_floored_r), .below_floor_r(below_floor_r),
   .vad_raw_r(vad_raw_r), .busy_r(busy_r), .done_r(done_r));

// File: tb/vad_encoder_model.sv
module vad_encoder_model
   import vad_pkg::*;
(
   input  wire logic                clk,      // bench clock
   input  wire logic                send,     // hand a frame over
   input  wire vad_pkg::vad_frame_t frame_in, // operands to hand over
   output logic                     start,    // frame valid strobe
   output vad_pkg::vad_frame_t      frame     // operands to the block
);
   timeunit 1ns;
   timeprecision 100ps;
   vad_frame_t stale_r = '0;
   // outside a handover the bus toggles, so late sampling shows up
   always @(posedge clk) stale_r <= ~frame;
   assign start = send;
   assign frame = send ? frame_in : stale_r;
endmodule

// File: tb/vad_pole_test_tb.sv
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t got %h expected %h", $time, (g), (e)); end end
module vad_pole_test_tb
   import vad_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam vad_pf_t PLEV_X = '{16'sh0013, 16'h54A3};
   logic       clk, nrst, send, start, busy_r, done_r, tone_r;
   logic       below_floor_r, vad_raw_r;
   vad_frame_t fin, frame;
   vad_pf_t    thvad, thr_scale, pvad_r, input_frame_energy_r, ceiling_r;
   vad_pf_t    thr_scaled_r, thr_floored_r;
   int         n_errors, n_compared;
   // {tone, coefficients 4 to 1}: real, high, low, error pass, error fail
   logic [64:0] tab [5] = '{{1'b0, 64'h7333_7333_E666_0000},
      {1'b1, 64'h7333_7333_199A_5CCD}, {1'b0, 64'h7333_7333_199A_A333},
      {1'b1, 64'h7333_7333_199A_C000}, {1'b0, 64'h0000_0000_199A_C000}};

   vad_encoder_model vad_encoder_model_i (.clk(clk), .send(send),
      .frame_in(fin), .start(start), .frame(frame));
   vad_pole_test vad_pole_test_i (.clk(clk), .nrst(nrst), .start(start),
      .frame(frame), .thvad(thvad), .thr_scale(thr_scale), .pvad_r(pvad_r),
      .input_frame_energy_r(input_frame_energy_r), .ceiling_r(ceiling_r),
      .thr_scaled_r(thr_scaled_r), .thr_floored_r(thr_floored_r),
      .below_floor_r(below_floor_r), .vad_raw_r(vad_raw_r),
      .tone_r(tone_r), .busy_r(busy_r), .done_r(done_r));

   task automatic conclude();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // energy from lags 0 and 1 only, unit coefficient correlation
   function automatic vad_frame_t mk(input logic [31:0] a0, a1,
                                     input logic [63:0] coeffs);
      vad_frame_t f;
      f = '0;
      f.acf[0] = a0;
      f.acf[1] = a1;
      f.fcorr[0] = 16'h0001;
      f.fcorr[1] = 16'h0001;
      f.reflection_coeffs = coeffs;
      return f;
   endfunction

   // second strobe lands while busy and must be ignored
   task automatic run_frame(input vad_frame_t f);
      int k;
      @(negedge clk) send = 1'b1;
      fin = f;
      @(negedge clk) send = 1'b0;
      repeat (3) @(negedge clk);
      send = 1'b1;
      fin = ~f;
      @(negedge clk) send = 1'b0;
      for (k = 0; k < 20 && done_r !== 1'b1; k++) @(negedge clk);
      if (done_r !== 1'b1) begin
         n_errors++;
         conclude();
      end
      // step past the done edge: the checker still samples thvad there
      @(negedge clk);
   endtask

   task automatic t_reset();
      `CHK(thr_floored_r, PLEV_X)
      `CHK(ceiling_r, 32'h001B_421F)
      `CHK({busy_r, done_r, tone_r}, 3'h0)
      $display("reset test done");
   endtask

   task automatic t_energy();
      thvad = '{16'sh0012, 16'h4000};
      run_frame(mk(32'h0001_0000, 32'h0000_8000, '0));
      `CHK(pvad_r, 32'h0012_4000)
      `CHK(input_frame_energy_r, 32'h0011_4000)
      `CHK({vad_raw_r, below_floor_r}, 2'h1)
      `CHK(ceiling_r, 32'h001B_423F)
      `CHK(thr_scaled_r, 32'h0012_4000)
      thvad = '{16'sh0011, 16'h7FFF};
      run_frame(mk(32'h0001_0000, 32'h0000_8000, '0));
      `CHK({vad_raw_r, thr_floored_r}, {1'b1, PLEV_X})
      `CHK(thr_scaled_r, 32'h0011_7FFF)
      thvad = '{16'sh0014, 16'h4000};
      thr_scale = '{16'sh0002, 16'h6000};
      run_frame(mk(32'h0004_0000, 32'h0, '0));
      `CHK(pvad_r, 32'h0013_4000)
      `CHK({vad_raw_r, below_floor_r}, 2'h0)
      `CHK(thr_floored_r, thvad)
      `CHK(thr_scaled_r, 32'h0015_6000)
      `CHK(ceiling_r, 32'h001B_425F)
      $display("energy test done");
   endtask

   task automatic t_tone();
      for (int i = 0; i < 5; i++) begin
         run_frame(mk(32'h0001_0000, 32'h0, tab[i][63:0]));
         `CHK(tone_r, tab[i][64])
      end
      $display("tone test done");
   endtask

   // reset in mid-frame drops the frame and restores the idle values
   task automatic t_reset_mid();
      @(negedge clk) send = 1'b1;
      fin = mk(32'h0001_0000, 32'h0, '0);
      @(negedge clk) send = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b0;
      @(negedge clk) nrst = 1'b1;
      `CHK({busy_r, pvad_r}, {1'b0, 16'sh8000, 16'h4000})
      repeat (12) @(negedge clk);
      `CHK(done_r, 1'b0)
      $display("mid-run reset test done");
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // inputs move on falling edges, away from the sampling edge
   initial begin
      nrst = 1'b0;
      send = 1'b0;
      fin = '0;
      thvad = '0;
      thr_scale = '{16'sh0001, 16'h4000};
      n_errors = 0;
      n_compared = 0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      t_reset();
      t_energy();
      t_tone();
      t_reset_mid();
      conclude();
   end
endmodule
